// ---- hw/tdm_port.sv ----
// Codec end of the time-multiplexed serial audio port, with frame one-shot.
// Assumes bit clock, frame clock and serial input come from outside this clock domain.
`timescale 1ns/1ns

// Operation
// R1 - Every frame carries 256 bit periods each way, shifted by the bit clock.
// R2 - The first bit of a frame sits in the bit period that starts at the frame clock's falling edge.
// R3 - Output frame is left sample, unused slot, 64 idle bits, right sample, unused slot, 64 idle bits.
// R4 - The processor fills the first half toward the codec with right surround, center, left, empty.
// R5 - The processor fills the second half with bass, left surround, right, empty.
// R6 - While muted the processor sends only zero bits.
// R7 - The processor starts muted and stays so until an unmute or volume-up command.
// R8 - One narrow pulse is made on each falling frame clock edge as the frame-start mark.
// R9 - The pulse is timed by the bit clock and lasts one bit period, once per frame.
// R10 - A continuous bit clock times every serial transfer in and out.
// R11 - The receiving processor captures data on the bit clock and takes the frame clock as sample start.
// R12 - The second processor shifts its output in on the same bit and frame clocks.
// R13 - The processor link clock runs at 40 MHz or 20 MHz, by firmware revision.
// R14 - The link frame sync is one pulse of one serial clock period.
// R15 - Link audio moves in 256-sample blocks, one burst about every 5.8 ms.
// R16 - Slots go most significant bit first and idle slots carry zeros.
// R17 - Data changes on the falling bit clock edge and is sampled on the rising one, both ways.
module tdm_port
  import tdm_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH,
  parameter int BLOCK_FRAMES = FRAMES_PER_BLOCK
)(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Serial link
  input wire logic BIT_CLOCK,
  input wire logic FRAME_CLOCK_LINE,
  output logic CODEC_SERIAL_OUT,
  input wire logic CODEC_SERIAL_IN,
  // Frame and block marks
  output logic FRAME_ONE_SHOT,
  output logic BLOCK_SYNC,
  // Converter samples to send
  input wire logic [SLOT_BITS-1:0] LEFT_SAMPLE,
  input wire logic [SLOT_BITS-1:0] RIGHT_SAMPLE,
  // Received slots
  output logic [SLOT_BITS-1:0] RX_WORD,
  output logic [SLOT_W-1:0] RX_SLOT,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_OVERRUN
);
  localparam int BW = SLOT_W + SLOT_BITS;
  // Frame count at which a block ends; the counter wraps here
  localparam logic [CNT_W-1:0] LAST_FRAME = CNT_W'(BLOCK_FRAMES - 1);

  // Synchronisers
  logic bclk_meta_q, bclk_sync_q, bclk_prev_q;
  logic fclk_meta_q, fclk_sync_q;
  logic sdin_meta_q, sdin_sync_q;
  logic bclk_rise, bclk_fall, frame_start;

  // Serial engine
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] frames_q, frames_d;
  logic [SLOT_BITS-1:0] left_q, left_d, right_q, right_d, rx_q, rx_d;
  logic fat_q, fat_d, out_q, out_d, shot_q, shot_d, block_q, block_d;
  logic started_q, started_d, overrun_q, overrun_d;
  logic push;

  stream_if #(.W(BW)) fill_s ();
  stream_if #(.W(BW)) drain_s ();

  function automatic logic slot_bit(input logic [CNT_W-1:0] c, input logic [SLOT_BITS-1:0] l,
                                    input logic [SLOT_BITS-1:0] r);
    logic [4:0] idx;
    idx = ~c[4:0];
    if (c[7:5] == SLOT_LEFT)
      slot_bit = l[idx];
    else if (c[7:5] == SLOT_RIGHT)
      slot_bit = r[idx];
    else
      slot_bit = 1'b0;
  endfunction

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      bclk_meta_q <= 1'b0;
      bclk_sync_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      fclk_meta_q <= 1'b0;
      fclk_sync_q <= 1'b0;
      sdin_meta_q <= 1'b0;
      sdin_sync_q <= 1'b0;
    end
    else
    begin
      bclk_meta_q <= BIT_CLOCK;
      bclk_sync_q <= bclk_meta_q;
      bclk_prev_q <= bclk_sync_q;
      fclk_meta_q <= FRAME_CLOCK_LINE;
      fclk_sync_q <= fclk_meta_q;
      sdin_meta_q <= CODEC_SERIAL_IN;
      sdin_sync_q <= sdin_meta_q;
    end
  end

  assign bclk_rise = bclk_sync_q && !bclk_prev_q; // R10
  assign bclk_fall = !bclk_sync_q && bclk_prev_q; // R10
  // Frame clock seen high at the last fall, low now
  assign frame_start = bclk_fall && fat_q && !fclk_sync_q; // R2

  always_comb
  begin
    cnt_d = cnt_q;
    frames_d = frames_q;
    left_d = left_q;
    right_d = right_q;
    rx_d = rx_q;
    fat_d = fat_q;
    out_d = out_q;
    shot_d = shot_q;
    block_d = block_q;
    started_d = started_q;
    overrun_d = overrun_q;
    push = 1'b0;
    if (bclk_fall)
    begin
      fat_d = fclk_sync_q;
      shot_d = 1'b0; // R9
      block_d = 1'b0; // R14
      if (frame_start)
      begin
        cnt_d = CNT_ZERO; // R1
        left_d = LEFT_SAMPLE;
        right_d = RIGHT_SAMPLE;
        out_d = LEFT_SAMPLE[SLOT_BITS-1]; // R2
        shot_d = 1'b1; // R8
        started_d = 1'b1;
        frames_d = (frames_q == LAST_FRAME) ? CNT_ZERO : frames_q + CNT_ONE; // R15
        block_d = (frames_q == LAST_FRAME); // R15
      end
      else if (started_q)
      begin
        cnt_d = cnt_q + CNT_ONE; // R1
        out_d = slot_bit(cnt_q + CNT_ONE, left_q, right_q); // R3 R16 R17
      end
    end
    if (bclk_rise && started_q)
    begin
      rx_d = {rx_q[SLOT_BITS-2:0], sdin_sync_q}; // R17 R16
      if (cnt_q[4:0] == LAST_BIT_IN_SLOT && cnt_q[7:5] != SLOT_EMPTY_LO && cnt_q[7:5] != SLOT_EMPTY_HI)
        push = 1'b1;
    end
    if (push && !fill_s.ready)
      overrun_d = 1'b1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      cnt_q <= CNT_ZERO;
      frames_q <= CNT_ZERO;
      left_q <= '0;
      right_q <= '0;
      rx_q <= '0;
      fat_q <= 1'b0;
      out_q <= 1'b0;
      shot_q <= 1'b0;
      block_q <= 1'b0;
      started_q <= 1'b0;
      overrun_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      frames_q <= frames_d;
      left_q <= left_d;
      right_q <= right_d;
      rx_q <= rx_d;
      fat_q <= fat_d;
      out_q <= out_d;
      shot_q <= shot_d;
      block_q <= block_d;
      started_q <= started_d;
      overrun_q <= overrun_d;
    end
  end

  // Completed slot goes to the buffer with its slot number
  assign fill_s.valid = push;
  assign fill_s.data = {cnt_q[7:5], rx_d};

  word_buffer #(.W(BW), .DEPTH(DEPTH)) rx_buf (
    .clk(SYS_CLK),
    .rst(RESET),
    .fill(fill_s),
    .drain(drain_s)
  );

  assign drain_s.ready = RX_READY;
  assign RX_VALID = drain_s.valid;
  assign RX_SLOT = drain_s.data[BW-1:SLOT_BITS];
  assign RX_WORD = drain_s.data[SLOT_BITS-1:0];
  assign CODEC_SERIAL_OUT = out_q;
  assign FRAME_ONE_SHOT = shot_q;
  assign BLOCK_SYNC = block_q;
  assign RX_OVERRUN = overrun_q;
endmodule

// ---- inc/tdm_pkg.sv ----
// Constants of the time-multiplexed codec serial port.
// Assumes one system clock; the bit and frame clocks arrive as sampled inputs.
package tdm_pkg;
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int BIT_CLK_HZ = 11_289_600;
  localparam int FRAME_CLK_HZ = 44_100;
  localparam int BITS_PER_FRAME = 256;
  localparam int SLOT_BITS = 32;
  localparam int CNT_W = 8;
  localparam int SLOT_W = 3;
  localparam int FRAMES_PER_BLOCK = 256;
  localparam int RX_DEPTH = 2;
  localparam logic [SLOT_W-1:0] SLOT_LEFT = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_RIGHT = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_EMPTY_LO = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_EMPTY_HI = 3'h7;
  localparam logic [4:0] LAST_BIT_IN_SLOT = 5'h1f;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] LAST_FRAME_IN_BLOCK = 8'hff;
endpackage

// ---- inc/stream_if.sv ----
// Valid/ready word stream between the port engine and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface stream_if #(parameter int W = 35);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- hw/word_buffer.sv ----
// Small first-in first-out buffer of flip-flops with valid/ready on both sides.
// Assumes a synchronous active-high reset on the same clock as its user.
`timescale 1ns/1ns
module word_buffer #(
  parameter int W = 35,
  parameter int DEPTH = 2
)(
  input wire logic clk,
  input wire logic rst,
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = (PW)'(DEPTH - 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] count_q, count_d;
  logic do_wr, do_rd;

  assign fill.ready = (count_q != FULL_COUNT);
  assign drain.valid = (count_q != '0);
  assign drain.data = mem_q[rd_q];
  assign do_wr = fill.valid && fill.ready;
  assign do_rd = drain.valid && drain.ready;

  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    if (do_wr)
    begin
      mem_d[wr_q] = fill.data;
      wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
    end
    if (do_rd)
      rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
    if (do_wr && !do_rd)
      count_d = count_q + 1'b1;
    else if (do_rd && !do_wr)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
      mem_q <= mem_d;
    end
  end
endmodule

// ---- sim/tdm_port_chk.sv ----
// Pin checks on the codec serial port.
// Assumes binding to the port's top module.
`timescale 1ns/1ns
module tdm_port_chk
  import tdm_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Serial side
  input wire logic BIT_CLOCK,
  input wire logic FRAME_CLOCK_LINE,
  input wire logic CODEC_SERIAL_OUT,
  input wire logic FRAME_ONE_SHOT,
  input wire logic BLOCK_SYNC,
  input wire logic [SLOT_BITS-1:0] LEFT_SAMPLE,
  // Receive side
  input wire logic [SLOT_BITS-1:0] RX_WORD,
  input wire logic [SLOT_W-1:0] RX_SLOT,
  input wire logic RX_VALID,
  input wire logic RX_READY
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence s_pulse;
    FRAME_ONE_SHOT [*7] ##[1:2] !FRAME_ONE_SHOT;
  endsequence
  a_pulse_width: assert property ($rose(FRAME_ONE_SHOT) |-> s_pulse)
    else $error("pulse width");
  a_pulse_start: assert property ($fell(FRAME_CLOCK_LINE) |-> ##[2:6] $rose(FRAME_ONE_SHOT))
    else $error("no pulse");
  a_first_bit: assert property ($rose(FRAME_ONE_SHOT) |-> CODEC_SERIAL_OUT == $past(LEFT_SAMPLE[31]))
    else $error("first bit");
  a_out_steady: assert property ($changed(CODEC_SERIAL_OUT) |=> $stable(CODEC_SERIAL_OUT) [*6])
    else $error("bit too short");
  a_out_edge: assert property ($changed(CODEC_SERIAL_OUT) |-> !$past(BIT_CLOCK, 2))
    else $error("bit off edge");
  a_rx_hold: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD) && $stable(RX_SLOT))
    else $error("word not held");
  a_rx_slot: assert property (RX_VALID |-> RX_SLOT != SLOT_EMPTY_LO && RX_SLOT != SLOT_EMPTY_HI)
    else $error("empty slot out");
  a_block_mark: assert property (BLOCK_SYNC |-> FRAME_ONE_SHOT)
    else $error("block mark");
endmodule
bind tdm_port tdm_port_chk chk_u (.SYS_CLK, .RESET, .BIT_CLOCK, .FRAME_CLOCK_LINE, .CODEC_SERIAL_OUT,
  .FRAME_ONE_SHOT, .BLOCK_SYNC, .LEFT_SAMPLE, .RX_WORD, .RX_SLOT, .RX_VALID, .RX_READY);

// ---- sim/proc_model.sv ----
// Processor side: clocks, slot data in, codec data captured.
// Assumes the port samples these lines with its own clock.
`timescale 1ns/1ns
module proc_model (
  // Serial lines
  output logic bclk,
  output logic fclk,
  output logic sdin,
  input wire logic sdout,
  // Last captured frame
  output logic [255:0] got,
  output int frames
);
  logic [31:0] w;
  int b;
  initial
  begin
    bclk = 1'b1;
    fclk = 1'b1;
    sdin = 1'b0;
    frames = 0;
    got = '0;
    #687 bclk = 1'b0;
    #160 bclk = 1'b1;
    #160;
    forever
    begin
      for (b = 0; b < 256; b++)
      begin
        // Muted frames 0 and 1; empty slots zero
        w = (frames < 2 || b[6:5] == 2'h3) ? 32'h0 : {8'hA5, frames[7:0], 13'h0, b[7:5]};
        bclk = 1'b0;
        fclk = b[7];
        sdin = w[31-b[4:0]];
        #160 bclk = 1'b1;
        got[255-b] = sdout;
        #160;
      end
      frames++;
    end
  end
endmodule

// ---- sim/tdm_port_tb.sv ----
// Testbench of the codec serial port with random samples and stalls.
// Assumes the processor model drives the serial lines.
`timescale 1ns/1ns
module tdm_port_tb;
  import tdm_pkg::*;
  // Short block so the block mark shows up within the run
  localparam int BLK = 4;
  logic shot_prev;
  logic sys_clk, reset, bclk, fclk, sdin, sdout, one_shot, blk, rx_valid, rx_ready, ovr, stall;
  logic [31:0] left, right, rx_word, l, r;
  logic [SLOT_W-1:0] rx_slot;
  logic [255:0] got, exp_frame;
  int frames, seen, n_mismatch, num_checks, seed, ncyc, rf, ri;
  tdm_port #(.BLOCK_FRAMES(BLK)) dut_u (.SYS_CLK(sys_clk), .RESET(reset), .BIT_CLOCK(bclk), .FRAME_CLOCK_LINE(fclk),
    .CODEC_SERIAL_OUT(sdout), .CODEC_SERIAL_IN(sdin), .FRAME_ONE_SHOT(one_shot), .BLOCK_SYNC(blk),
    .LEFT_SAMPLE(left), .RIGHT_SAMPLE(right), .RX_WORD(rx_word), .RX_SLOT(rx_slot),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_OVERRUN(ovr));
  proc_model far_u (.bclk, .fclk, .sdin, .sdout, .got, .frames);
  task automatic cmp(input logic [255:0] g, input logic [255:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] slot_word(int f, int s);
    return (f < 2) ? 32'h0 : {8'hA5, f[7:0], 13'h0, s[2:0]};
  endfunction
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Check each finished frame, then load fresh samples
  always @(posedge sys_clk)
  begin
    if (frames != seen)
    begin
      seen = frames;
      cmp(got, exp_frame);
      l = $random(seed);
      r = $random(seed);
      left <= l;
      right <= r;
      exp_frame = {l, 96'h0, r, 96'h0};
    end
    if (!reset && rx_valid === 1'b1 && rx_ready)
    begin
      cmp(rx_slot, ri + (ri > 2));
      cmp(rx_word, slot_word(rf, ri + (ri > 2)));
      ri = (ri + 1) % 6;
      rf += (ri == 0);
    end
    // Block mark expected on the first pulse cycle of every BLK-th frame
    if (one_shot === 1'b1 && shot_prev !== 1'b1)
      cmp(blk, (frames % BLK) == BLK - 1);
    shot_prev = one_shot;
    rx_ready <= !stall && 1'($random(seed));
    ncyc++;
    if (ncyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    seed = 63795;
    reset = 1'b1;
    rx_ready = 1'b0;
    stall = 1'b0;
    left = 32'hFFFF_FFFF;
    right = 32'h8000_0001;
    exp_frame = {32'hFFFF_FFFF, 96'h0, 32'h8000_0001, 96'h0};
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    wait (frames == 5);
    @(posedge sys_clk);
    cmp(ovr, 1'b0);
    stall <= 1'b1;
    wait (frames == 6);
    @(posedge sys_clk);
    cmp(ovr, 1'b1);
    cmp(rx_slot, 0);
    cmp(rx_word, slot_word(5, 0));
    end_of_test();
  end
endmodule
